// File: src/ptu_timer_channels.sv
// channel logic of the pwm timer unit: capture, compare, edge and center pwm
// Functional notes
// - capture edge copies count into channel value
// - capture edge selectable rising, falling or both
// - byte read freezes captured word until other
// - capture event sets channel event flag
// - compare match sets, clears or toggles pin
// - compare value loads after both bytes written
// - edge pwm uses up counter, coexists
// - edge pwm polarity chosen by edge_level_sel_a
// - zero gives 0%, above modulus 100% duty
// - edge pwm value loads at count zero
// - centered mode: all channels, up/down, period 2*modulus
// - centered: zero or negative value 0% duty
// - centered: up match low, down match high
// - centered buffers load together at turn
// - control writes discard pending value bytes
// - pwm and compare match sets event flag
// - enabled interrupt follows flag level
// - flag clears by read-set then write zero
// - event between steps restarts clear sequence
// - wrap flag on up wrap or turn
// - mode bits pick capture, compare or pwm
`timescale 1ns/100ps
`include "ptu_defs.svh"
module ptu_timer_channels (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    centeredMode,
  input  wire logic                    wrapIrqEn,
  input  wire logic                    timerCtrlWr,
  input  wire logic                    modWrHi,
  input  wire logic                    modWrLo,
  input  wire ptu_pkg::ptu_byte_t      wrData,
  input  wire logic                    wrapFlagRd,
  input  wire logic                    wrapFlagClr,
  input  wire logic [`PTU_NUM_CH-1:0]  chModeB,
  input  wire logic [`PTU_NUM_CH-1:0]  chModeA,
  input  wire logic [`PTU_NUM_CH-1:0]  chEdgeB,
  input  wire logic [`PTU_NUM_CH-1:0]  chEdgeA,
  input  wire logic [`PTU_NUM_CH-1:0]  chIrqEn,
  input  wire logic [`PTU_NUM_CH-1:0]  chCtrlWr,
  input  wire logic [`PTU_NUM_CH-1:0]  chValWrHi,
  input  wire logic [`PTU_NUM_CH-1:0]  chValWrLo,
  input  wire logic [`PTU_NUM_CH-1:0]  chValRdHi,
  input  wire logic [`PTU_NUM_CH-1:0]  chValRdLo,
  input  wire logic [`PTU_NUM_CH-1:0]  chFlagRd,
  input  wire logic [`PTU_NUM_CH-1:0]  chFlagClr,
  input  wire logic [`PTU_NUM_CH-1:0]  chPinIn,
  output ptu_pkg::ptu_word_t           countView,
  output ptu_pkg::ptu_word_t           chValView [`PTU_NUM_CH],
  output logic [`PTU_NUM_CH-1:0]       chOut,
  output logic [`PTU_NUM_CH-1:0]       chOutEn,
  output logic [`PTU_NUM_CH-1:0]       chFlag,
  output logic [`PTU_NUM_CH-1:0]       chIrq,
  output logic                         wrapFlag,
  output logic                         wrapIrq
);
  import ptu_pkg::*;

  localparam int NCH = `PTU_NUM_CH;

  ptu_cnt_if cnt ();

  ptu_word_t          chValue   [NCH];
  ptu_byte_t          chHiBuf   [NCH];
  ptu_byte_t          chLoBuf   [NCH];
  ptu_mode_t          chMode    [NCH];
  ptu_sel_t           chEdge    [NCH];
  logic [NCH-1:0]     chHiDone;
  logic [NCH-1:0]     chLoDone;
  logic [NCH-1:0]     chLoad;
  logic [NCH-1:0]     chMatch;
  logic [NCH-1:0]     chCapEvt;
  logic [NCH-1:0]     chEvt;
  logic [NCH-1:0]     chArmed;
  logic [NCH-1:0]     next_chFlag;
  logic [NCH-1:0]     next_chArmed;
  logic [NCH-1:0]     chRdLock;
  logic [NCH-1:0]     chRdFirstHi;
  logic [NCH-1:0]     pinMeta;
  logic [NCH-1:0]     pinSync;
  logic [NCH-1:0]     pinPrev;
  logic               wrapArmed;
  logic               next_wrapFlag;
  logic               next_wrapArmed;

  // mode decode shared by every channel
  function automatic ptu_mode_t mode_of(input logic ctr, input logic b,
                                        input logic a);
    if (ctr) return MODE_CENTER_PWM;
    if (b)   return MODE_EDGE_PWM;
    if (a)   return MODE_COMPARE;
    return MODE_CAPTURE;
  endfunction

  // two-step flag clear, returns {flag, armed}; a new event always wins
  function automatic logic [1:0] flag_step(input logic flag,
    input logic armed, input logic evt, input logic rd, input logic clr);
    logic f;
    logic a;
    f = flag;
    a = armed;
    if (rd && flag) a = 1'b1;
    if (clr && armed) begin
      f = 1'b0;
      a = 1'b0;
    end
    if (evt) begin
      f = 1'b1;
      a = 1'b0;
    end
    return {f, a};
  endfunction

  ptu_counter u_counter (
    .clk          (clk),
    .rst          (rst),
    .centeredMode (centeredMode),
    .timerCtrlWr  (timerCtrlWr),
    .modWrHi      (modWrHi),
    .modWrLo      (modWrLo),
    .wrData       (wrData),
    .cnt          (cnt.src)
  );

  assign countView = cnt.count;

  // capture pins cross in from outside; the first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMeta <= '0;
      pinSync <= '0;
      pinPrev <= '0;
    end else begin
      pinMeta <= chPinIn;
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  // per-channel events and buffer load conditions
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      chMode[i]   = mode_of(centeredMode, chModeB[i], chModeA[i]);
      chEdge[i]   = {chEdgeB[i], chEdgeA[i]};
      chMatch[i]  = (cnt.count == chValue[i]);
      unique case (chEdge[i])
        `PTU_EDGE_OFF:  chCapEvt[i] = 1'b0;
        `PTU_EDGE_RISE: chCapEvt[i] = pinSync[i] && !pinPrev[i];
        `PTU_EDGE_FALL: chCapEvt[i] = !pinSync[i] && pinPrev[i];
        `PTU_EDGE_BOTH: chCapEvt[i] = pinSync[i] != pinPrev[i];
      endcase
      chCapEvt[i] = chCapEvt[i] && chMode[i] == MODE_CAPTURE;
      chEvt[i]    = (chMode[i] == MODE_CAPTURE) ? chCapEvt[i]
                                                : chMatch[i];
      unique case (chMode[i])
        MODE_EDGE_PWM:   chLoad[i] = cnt.atZero;
        MODE_CENTER_PWM: chLoad[i] = cnt.wrapEvt;
        default:         chLoad[i] = 1'b1;
      endcase
      chLoad[i] = chLoad[i] && chHiDone[i] && chLoDone[i];
      {next_chFlag[i], next_chArmed[i]} = flag_step(chFlag[i],
        chArmed[i], chEvt[i], chFlagRd[i], chFlagClr[i]);
    end
    {next_wrapFlag, next_wrapArmed} = flag_step(wrapFlag, wrapArmed,
      cnt.wrapEvt, wrapFlagRd, wrapFlagClr);
  end

  // channel value: capture takes priority over a pending buffered load
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        chValue[i] <= `PTU_VAL_RST;
        chHiBuf[i] <= `PTU_BYTE_RST;
        chLoBuf[i] <= `PTU_BYTE_RST;
      end
      chHiDone <= '0;
      chLoDone <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (chCapEvt[i]) begin
          chValue[i] <= cnt.count;
        end else if (chLoad[i]) begin
          chValue[i] <= {chHiBuf[i], chLoBuf[i]};
        end
        if (chCtrlWr[i]) begin
          chHiDone[i] <= 1'b0;
          chLoDone[i] <= 1'b0;
        end else begin
          if (chLoad[i]) begin
            chHiDone[i] <= 1'b0;
            chLoDone[i] <= 1'b0;
          end
          if (chValWrHi[i]) begin
            chHiBuf[i]  <= wrData;
            chHiDone[i] <= 1'b1;
          end
          if (chValWrLo[i]) begin
            chLoBuf[i]  <= wrData;
            chLoDone[i] <= 1'b1;
          end
        end
      end
    end
  end

  // read view: follows the value until a byte read freezes it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        chValView[i] <= `PTU_VAL_RST;
      end
      chRdLock    <= '0;
      chRdFirstHi <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (!chRdLock[i]) begin
          chValView[i] <= chValue[i];
        end
        if (chCtrlWr[i]) begin
          chRdLock[i] <= 1'b0;
        end else if (!chRdLock[i] && (chValRdHi[i] || chValRdLo[i])) begin
          chRdLock[i]    <= 1'b1;
          chRdFirstHi[i] <= chValRdHi[i];
        end else if (chRdLock[i] && (chRdFirstHi[i] ? chValRdLo[i]
                                                    : chValRdHi[i])) begin
          chRdLock[i] <= 1'b0;
        end
      end
    end
  end

  // pin drive is registered so a match never glitches the pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chOut   <= '0;
      chOutEn <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        chOutEn[i] <= chMode[i] != MODE_CAPTURE && chEdge[i] != `PTU_EDGE_OFF;
        unique case (chMode[i])
          MODE_CAPTURE: chOut[i] <= chOut[i];
          MODE_COMPARE: begin
            if (chMatch[i]) begin
              unique case (chEdge[i])
                `PTU_EDGE_OFF:  chOut[i] <= chOut[i];
                `PTU_OC_TOGGLE: chOut[i] <= !chOut[i];
                `PTU_OC_CLEAR:  chOut[i] <= 1'b0;
                `PTU_OC_SET:    chOut[i] <= 1'b1;
              endcase
            end
          end
          // high from wrap to match; 0 never high, above modulus always
          MODE_EDGE_PWM: chOut[i] <= (cnt.count < chValue[i])
                                     ^ chEdgeA[i];
          // low from the up match, high again from the down match, so the
          // matching count itself counts once and the pulse is 2*value wide
          MODE_CENTER_PWM: chOut[i] <= (chValue[i] != `PTU_ZERO
            && !chValue[i][`PTU_SIGN_BIT]
            && (cnt.count < chValue[i]
                || (cnt.countDown && cnt.count == chValue[i])))
            ^ chEdgeA[i];
        endcase
      end
    end
  end

  // flags and static interrupt requests, registered from the next flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chFlag    <= '0;
      chArmed   <= '0;
      chIrq     <= '0;
      wrapFlag  <= 1'b0;
      wrapArmed <= 1'b0;
      wrapIrq   <= 1'b0;
    end else begin
      chFlag    <= next_chFlag;
      chArmed   <= next_chArmed;
      chIrq     <= next_chFlag & chIrqEn;
      wrapFlag  <= next_wrapFlag;
      wrapArmed <= next_wrapArmed;
      wrapIrq   <= next_wrapFlag && wrapIrqEn;
    end
  end

  // checks watch channel 0, capture and read lock channel 1 where the
  // bench drives them; every channel shares the same logic
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_capture_copy: assert property (chCapEvt[1]
    |=> chValue[1] == $past(cnt.count) && chFlag[1])
    else $error("capture did not copy count or set flag");
  a_oc_toggle: assert property (chMode[0] == MODE_COMPARE
    && chEdge[0] == `PTU_OC_TOGGLE && chMatch[0]
    |=> chOut[0] != $past(chOut[0]))
    else $error("compare match did not toggle pin");
  a_oc_load: assert property (chMode[0] == MODE_COMPARE
    && chHiDone[0] && chLoDone[0] && !chCtrlWr[0]
    |=> chValue[0] == {$past(chHiBuf[0]), $past(chLoBuf[0])})
    else $error("compare value not loaded after both bytes");
  a_pwm_rise: assert property (chMode[0] == MODE_EDGE_PWM
    && !chEdgeA[0] && cnt.atZero && chValue[0] != `PTU_ZERO
    |=> chOut[0])
    else $error("edge pwm not high after wrap");
  a_pwm_load: assert property (chMode[0] == MODE_EDGE_PWM
    && $changed(chValue[0]) && $past(chMode[0]) == MODE_EDGE_PWM
    |-> $past(cnt.atZero))
    else $error("edge pwm value moved away from count zero");
  a_centered_pwm_zero: assert property (chMode[0] == MODE_CENTER_PWM
    && !chEdgeA[0] && chValue[0][`PTU_SIGN_BIT] ##1
    chMode[0] == MODE_CENTER_PWM && !chEdgeA[0] |-> !chOut[0])
    else $error("negative value produced center pwm pulse");
  a_centered_pwm_load: assert property (chMode[0] == MODE_CENTER_PWM
    && $past(chMode[0]) == MODE_CENTER_PWM && $changed(chValue[0])
    |-> $past(cnt.wrapEvt))
    else $error("center pwm value moved outside the turn");
  a_flag_hold: assert property (chFlag[0] && chFlagClr[0]
    && !chArmed[0] |=> chFlag[0])
    else $error("flag cleared without prior read");
  a_event_restart: assert property (chArmed[0] && chEvt[0]
    |=> chFlag[0] && !chArmed[0])
    else $error("event during clear did not restart sequence");
  a_irq_level: assert property (##1 chIrq[0] ==
    (chFlag[0] && $past(chIrqEn[0])))
    else $error("interrupt request does not follow flag");
  a_read_freeze: assert property (chRdLock[1] && !chCtrlWr[1]
    && !(chRdFirstHi[1] ? chValRdLo[1] : chValRdHi[1])
    |=> $stable(chValView[1]) && chRdLock[1])
    else $error("captured read view not frozen");
  a_val_cancel: assert property (chCtrlWr[0]
    |=> !chHiDone[0] && !chLoDone[0] && !chRdLock[0])
    else $error("channel control write left bytes pending");

  c_capture: cover property (chCapEvt[1] ##1 chFlag[1]);
  c_flag_clear: cover property (chArmed[0] ##1 !chFlag[0]);
  c_centered_pwm_pulse: cover property (chMode[0] == MODE_CENTER_PWM
    && !chOut[0] ##1 chOut[0]);
endmodule // ptu_timer_channels

// File: src/ptu_defs.svh
// constants of the pwm timer unit: widths, reset values, codes, limits
`ifndef PTU_DEFS_SVH
`define PTU_DEFS_SVH

`define PTU_NUM_CH     2
`define PTU_SIGN_BIT   15
`define PTU_ZERO       16'h0000
`define PTU_ONE        16'h0001
`define PTU_CNT_MAX    16'hFFFF
`define PTU_VAL_RST    16'h0000
`define PTU_MOD_RST    16'h0000
`define PTU_BYTE_RST   8'h00
// edge / level select codes {edge_level_sel_b, edge_level_sel_a}
`define PTU_EDGE_OFF   2'h0
`define PTU_EDGE_RISE  2'h1
`define PTU_EDGE_FALL  2'h2
`define PTU_EDGE_BOTH  2'h3
// output compare actions on the same two bits
`define PTU_OC_TOGGLE  2'h1
`define PTU_OC_CLEAR   2'h2
`define PTU_OC_SET     2'h3

`endif

// File: src/ptu_pkg.sv
// types shared by the pwm timer unit modules
package ptu_pkg;
  typedef logic [15:0] ptu_word_t;
  typedef logic [7:0]  ptu_byte_t;
  typedef logic [1:0]  ptu_sel_t;
  typedef enum logic [1:0] {
    MODE_CAPTURE,
    MODE_COMPARE,
    MODE_EDGE_PWM,
    MODE_CENTER_PWM
  } ptu_mode_t;
endpackage

// File: src/ptu_cnt_if.sv
// counter state handed from the counter to the channel logic
`timescale 1ns/100ps
interface ptu_cnt_if;
  import ptu_pkg::*;
  ptu_word_t count;
  ptu_word_t modulus;
  logic      countDown;
  logic      wrapEvt;
  logic      atZero;
  modport src (output count, modulus, countDown, wrapEvt, atZero);
  modport dst (input count, modulus, countDown, wrapEvt, atZero);
endinterface

// File: src/ptu_counter.sv
// main 16-bit counter with byte-buffered modulus, up or up/down counting
`timescale 1ns/100ps
`include "ptu_defs.svh"
module ptu_counter (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         centeredMode,
  input  wire logic         timerCtrlWr,
  input  wire logic         modWrHi,
  input  wire logic         modWrLo,
  input  wire ptu_pkg::ptu_byte_t wrData,
  ptu_cnt_if.src            cnt
);
  import ptu_pkg::*;

  ptu_word_t count;
  ptu_word_t modulus;
  ptu_word_t terminal;
  ptu_byte_t modHiBuf;
  ptu_byte_t modLoBuf;
  logic      modHiDone;
  logic      modLoDone;
  logic      down;
  logic      wrapEvt;
  logic      modLoad;

  // in up counting a zero modulus means free running to the maximum count
  assign terminal = (modulus == `PTU_ZERO) ? `PTU_CNT_MAX : modulus;
  // wrap marks the edge that leaves the terminal count
  assign wrapEvt  = centeredMode ? (!down && count == modulus)
                                 : (count == terminal);
  // centered mode holds new bytes until the turn so all buffers move together
  assign modLoad  = modHiDone && modLoDone && (!centeredMode || wrapEvt);

  assign cnt.count     = count;
  assign cnt.modulus   = modulus;
  assign cnt.countDown = down;
  assign cnt.wrapEvt   = wrapEvt;
  assign cnt.atZero    = (count == `PTU_ZERO);

  // counting: up with wrap, or up to modulus and back down to zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= `PTU_ZERO;
      down  <= 1'b0;
    end else if (!centeredMode) begin
      down  <= 1'b0;
      count <= wrapEvt ? `PTU_ZERO : count + `PTU_ONE;
    end else if (!down) begin
      if (count >= modulus) begin
        down  <= 1'b1;
        count <= count - `PTU_ONE;
      end else begin
        count <= count + `PTU_ONE;
      end
    end else if (count == `PTU_ZERO) begin
      down  <= 1'b0;
      count <= `PTU_ONE;
    end else begin
      count <= count - `PTU_ONE;
    end
  end

  // modulus byte buffers; a timer control write drops pending bytes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modulus   <= `PTU_MOD_RST;
      modHiBuf  <= `PTU_BYTE_RST;
      modLoBuf  <= `PTU_BYTE_RST;
      modHiDone <= 1'b0;
      modLoDone <= 1'b0;
    end else begin
      if (timerCtrlWr) begin
        modHiDone <= 1'b0;
        modLoDone <= 1'b0;
      end else begin
        if (modLoad) begin
          modulus   <= {modHiBuf, modLoBuf};
          modHiDone <= 1'b0;
          modLoDone <= 1'b0;
        end
        if (modWrHi) begin
          modHiBuf  <= wrData;
          modHiDone <= 1'b1;
        end
        if (modWrLo) begin
          modLoBuf  <= wrData;
          modLoDone <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_center_turn: assert property (centeredMode && !down &&
    count == modulus && modulus != `PTU_ZERO
    |=> down && count == $past(modulus) - `PTU_ONE)
    else $error("counter did not turn down at modulus");
  a_up_wrap_zero: assert property (!centeredMode && wrapEvt
    |=> count == `PTU_ZERO)
    else $error("up counter did not wrap to zero");
  a_mod_cancel: assert property (timerCtrlWr
    |=> !modHiDone && !modLoDone)
    else $error("timer control write left modulus bytes pending");
  c_center_turn: cover property (centeredMode && wrapEvt);
endmodule // ptu_counter

// File: sim/ptu_pin_model.sv
// pin-side partner: drives the capture pins and measures output duty
`timescale 1ns/100ps
module ptu_pin_model (
  input  wire logic       clk,
  input  wire logic [1:0] pinOut,
  output logic      [1:0] pinIn
);
  initial pinIn = 2'b00;

  // an external source changes its pin just after the falling edge
  task automatic drive(input int ch, input logic lvl);
    @(negedge clk);
    pinIn[ch] = lvl;
  endtask

  // counts high cycles of one output; a full period gives the pulse width
  task automatic duty(input int ch, input int n, output int hi);
    hi = 0;
    repeat (n) begin
      @(negedge clk);
      if (pinOut[ch] === 1'b1) hi++;
    end
  endtask
endmodule // ptu_pin_model

// File: sim/timer_channel_capture_pwm_tb_top.sv
// self-checking bench of the timer channel block
`timescale 1ns/100ps
`include "ptu_defs.svh"
module timer_channel_capture_pwm_tb_top;
  import ptu_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        centeredMode, wrapIrqEn, wrapFlag, wrapIrq, cntChk;
  logic [11:0] stb;
  logic [1:0]  stbCh, chModeB, chModeA, chEdgeB, chEdgeA, chIrqEn, chPinIn;
  logic [1:0]  chOut, chOutEn, chFlag, chIrq;
  ptu_byte_t   wrData;
  ptu_word_t   countView, mc, mMod, md;
  ptu_word_t   chValView [`PTU_NUM_CH];
  logic [31:0] seed = 32'hea8a;
  int          fails = 0;
  int          nCompared = 0;
  wire ptu_word_t term = (mMod == 16'h0000) ? 16'hFFFF : mMod;

  // strobe bits: 0/1 modulus bytes, 2/3 value bytes, 4/5 value reads,
  // 6/7 channel flag read/clear, 8 channel ctrl, 9/10 wrap flag, 11 timer ctrl
  ptu_timer_channels dut_u (
    .clk(clk), .rst(rst), .centeredMode(centeredMode),
    .wrapIrqEn(wrapIrqEn), .timerCtrlWr(stb[11]), .modWrHi(stb[0]),
    .modWrLo(stb[1]), .wrData(wrData), .wrapFlagRd(stb[9]),
    .wrapFlagClr(stb[10]), .chModeB(chModeB), .chModeA(chModeA),
    .chEdgeB(chEdgeB), .chEdgeA(chEdgeA), .chIrqEn(chIrqEn),
    .chCtrlWr({2{stb[8]}} & stbCh), .chValWrHi({2{stb[2]}} & stbCh),
    .chValWrLo({2{stb[3]}} & stbCh), .chValRdHi({2{stb[4]}} & stbCh),
    .chValRdLo({2{stb[5]}} & stbCh), .chFlagRd({2{stb[6]}} & stbCh),
    .chFlagClr({2{stb[7]}} & stbCh), .chPinIn(chPinIn),
    .countView(countView), .chValView(chValView), .chOut(chOut),
    .chOutEn(chOutEn), .chFlag(chFlag), .chIrq(chIrq),
    .wrapFlag(wrapFlag), .wrapIrq(wrapIrq));

  ptu_pin_model pins (.clk(clk), .pinOut(chOut), .pinIn(chPinIn));

  always #2.5 clk = ~clk;

  // reference up counter; only trusted while the modulus is known
  always @(posedge clk or posedge rst)
    if (rst) mc <= 16'h0000;
    else mc <= (mc == term) ? 16'h0000 : mc + 16'h0001;
  always @(negedge clk)
    if (cntChk) check("count", countView, mc);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrapUp();
    $display("compared %0d, mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one-cycle strobe; a gap cycle follows so no strobe is set twice at once
  task automatic strobe(input int s, input int ch, input ptu_byte_t d);
    @(negedge clk);
    stb[s] = 1'b1;
    stbCh = ch[0] ? 2'b10 : 2'b01;
    wrData = d;
    @(negedge clk);
    stb = 12'h000;
  endtask

  task automatic wrVal(input int ch, input ptu_word_t v);
    strobe(3, ch, v[7:0]);
    strobe(2, ch, v[15:8]);
  endtask

  // read step then write-zero step
  task automatic clr(input int s, input int ch);
    strobe(s, ch, 8'h00);
    strobe(s + 1, ch, 8'h00);
  endtask

  task automatic waitCnt(input ptu_word_t v);
    for (int i = 0; i < 300 && mc !== v; i++) @(negedge clk);
  endtask

  task automatic waitFlag(input int ch);
    for (int i = 0; i < 300 && chFlag[ch] !== 1'b1; i++) @(negedge clk);
    check("flag set", 16'(chFlag[ch]), 16'h0001);
  endtask

  // pin edge is synchronised over two edges, count of that cycle is taken
  task automatic capt(input logic lvl, input logic fire, output ptu_word_t e);
    pins.drive(1, lvl);
    repeat (2) @(posedge clk);
    @(negedge clk);
    e = mc;
    if (fire) begin
      waitFlag(1);
      repeat (2) @(negedge clk);
    end else begin
      repeat (4) @(negedge clk);
      check("no capture", 16'(chFlag[1]), 16'h0000);
    end
  endtask

  initial begin
    #(40000 * 5);
    fails++;
    wrapUp();
  end

  initial begin
    ptu_word_t v, e1, e2;
    int a, hi, ex;
    logic f;
    ptu_sel_t codes [3] = '{`PTU_EDGE_RISE, `PTU_EDGE_FALL, `PTU_EDGE_BOTH};
    ptu_sel_t acts [3] = '{`PTU_OC_SET, `PTU_OC_CLEAR, `PTU_OC_TOGGLE};
    {centeredMode, cntChk, stb, stbCh, wrData, mMod} = '0;
    {chModeB, chEdgeB, chEdgeA} = '0;
    {wrapIrqEn, chModeA, chIrqEn} = 5'b1_01_11;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    md = 16'h0020 + 16'(rnd() % 64);
    strobe(0, 0, md[15:8]);
    strobe(1, 0, md[7:0]);
    mMod = md;
    cntChk = 1'b1;
    // a lone high byte dropped by the timer ctrl write must never load
    strobe(0, 0, 8'hFF);
    strobe(11, 0, 8'h00);
    strobe(1, 0, md[7:0]);
    repeat (2 * md + 4) @(negedge clk);
    strobe(0, 0, md[15:8]);
    $display("test modulus done");
    for (int k = 0; k < 3; k++) begin
      v = 16'h0001 + 16'(rnd() % (md - 4));
      wrVal(0, v);
      waitCnt(v + 16'h0002);
      {chEdgeB[0], chEdgeA[0]} = acts[k];
      clr(6, 0);
      waitFlag(0);
      check("compare pin", 16'(chOut[0]), 16'(k != 1));
      check("compare oe", 16'(chOutEn[0]), 16'h0001);
      check("compare value", chValView[0], v);
      check("channel irq", 16'(chIrq[0]), 16'h0001);
      strobe(7, 0, 8'h00);
      check("clear unread", 16'(chFlag[0]), 16'h0001);
      clr(6, 0);
      check("clear flag", 16'(chFlag[0]), 16'h0000);
      check("irq drop", 16'(chIrq[0]), 16'h0000);
    end
    strobe(2, 0, 8'hA5);
    repeat (3) @(negedge clk);
    check("half write", chValView[0], v);
    strobe(8, 0, 8'h00);
    strobe(3, 0, 8'h5A);
    repeat (3) @(negedge clk);
    check("after ctrl", chValView[0], v);
    strobe(2, 0, 8'h3C);
    repeat (3) @(negedge clk);
    check("coherent", chValView[0], 16'h3C5A);
    $display("test compare done");
    for (int k = 0; k < 3; k++) begin
      {chEdgeB[1], chEdgeA[1]} = codes[k];
      for (a = 1; a >= 0; a--) begin
        f = a[0] ? codes[k][0] : codes[k][1];
        clr(6, 1);
        capt(a[0], f, e1);
        if (f) check("captured", chValView[1], e1);
      end
    end
    check("capture oe", 16'(chOutEn[1]), 16'h0000);
    clr(6, 1);
    capt(1'b1, 1'b1, e1);
    strobe(4, 1, 8'h00);
    clr(6, 1);
    capt(1'b0, 1'b1, e2);
    check("frozen", chValView[1], e1);
    strobe(5, 1, 8'h00);
    repeat (2) @(negedge clk);
    check("unfrozen", chValView[1], e2);
    $display("test capture done");
    waitCnt(16'h0005);
    clr(9, 0);
    waitCnt(term);
    check("wrap early", 16'(wrapFlag), 16'h0000);
    @(negedge clk);
    check("wrap set", 16'(wrapFlag), 16'h0001);
    check("wrap irq", 16'(wrapIrq), 16'h0001);
    // a wrap lands between the read step and the write step
    waitCnt(term - 16'h0002);
    strobe(9, 0, 8'h00);
    strobe(10, 0, 8'h00);
    check("restart", 16'(wrapFlag), 16'h0001);
    wrapIrqEn = 1'b0;
    @(negedge clk);
    check("irq masked", 16'(wrapIrq), 16'h0000);
    wrapIrqEn = 1'b1;
    clr(9, 0);
    check("wrap clear", 16'(wrapFlag), 16'h0000);
    $display("test wrap done");
    chModeB[0] = 1'b1;
    for (int k = 0; k < 6; k++) begin
      a = k % 2;
      {chEdgeB[0], chEdgeA[0]} = {1'b1, a[0]};
      v = (k < 2) ? 16'h0000 : (k < 4) ? md + 16'h0001 :
          16'h0001 + 16'(rnd() % md);
      wrVal(0, v);
      repeat (2 * md + 4) @(negedge clk);
      pins.duty(0, md + 1, hi);
      ex = (v > md) ? md + 1 : v;
      if (a != 0) ex = md + 1 - ex;
      check("edge duty", 16'(hi), 16'(ex));
    end
    waitCnt(16'h0004);
    wrVal(0, v + 16'h0001);
    waitCnt(md - 16'h0001);
    check("no early load", chValView[0], v);
    waitCnt(16'h0003);
    check("load at zero", chValView[0], v + 16'h0001);
    clr(6, 1);
    capt(1'b1, 1'b1, e1);
    check("coexist", chValView[1], e1);
    $display("test edge pwm done");
    cntChk = 1'b0;
    centeredMode = 1'b1; // modulus kept within 1..7FFF
    {chEdgeB[1], chEdgeA[1]} = 2'h2;
    for (int k = 0; k < 8; k++) begin
      a = k % 2;
      {chEdgeB[0], chEdgeA[0]} = {1'b1, a[0]};
      case (k / 2)
        0: v = 16'h0000;
        1: v = 16'h8000 | 16'(rnd());
        2: v = md + 16'h0001;
        // a value equal to the modulus matches only at the turn: left out
        default: v = 16'h0001 + 16'(rnd() % (md - 16'h0001));
      endcase
      wrVal(0, v);
      repeat (6 * md) @(negedge clk);
      pins.duty(0, 2 * md, hi);
      ex = (v == 16'h0000 || v[15]) ? 0 : (v > md) ? 2 * md : 2 * v;
      if (a != 0) ex = 2 * md - ex;
      check("center duty", 16'(hi), 16'(ex));
    end
    check("all centered", 16'(chOutEn[1]), 16'h0001);
    $display("test center pwm done");
    wrapUp();
  end
endmodule // timer_channel_capture_pwm_tb_top
